// File: rtl/mls_lane.sv
// Lane end: x8 serializer and deserializer, receive FIFO, input delay and low-power pad paths.
// Functional notes
// - Receive word is 8 bits on word clock.
// - Low-power pad levels are synchronised and glitch-filtered before reaching core.
// - Reversible lane lets core drive low-power pads.
// - FIFO empty flag shown on read clock.
// - Core pops FIFO with read request.
// - Receive reset clears FIFO and deserializer synchronously.
// - Clock lane gives core a divided word clock.
// - Forwarded clocks feed only receive data lanes.
// - Core controls differential input buffer enable.
// - Core controls high-speed input termination.
// - Strobe steps delay up or down by direction.
// - Delay clear returns counter to initial setting.
// - Clock lane makes bit, word and core clocks.
// - Transmit clocks come from a PLL.
// - Core gives fixed 8-bit transmit word.
// - Core drives per-pad low-power values and enables.
// - Reversible transmit lane returns sensed pad levels.
// - High-speed enable gates transmit driver onto pads.
// - High-speed is x8; low-power bypasses serdes.
// - Bit clock divided to form word clock.
`timescale 1ns/1ps
`default_nettype none
module mls_lane #(
   parameter int WIDTH = mls_pkg::WORD_W,
   parameter int DEPTH = mls_pkg::FIFO_DEPTH,
   parameter bit FIFO_ON = 1'b1
)
(
   input wire logic CLK,
   input wire logic RESET_N,
   mls_if.lane LINK,
   input wire logic PAD_P_IN,
   input wire logic PAD_N_IN,
   output logic PAD_P_OUT,
   output logic PAD_N_OUT,
   output logic PAD_P_OE,
   output logic PAD_N_OE,
   output logic CLOCK_LANE_WORD_CLOCK_FWD,
   output logic CLOCK_LANE_BIT_CLOCK_FWD,
   output logic CLOCK_LANE_CORE_CLOCK
);
   // CLK is the serial bit clock; the word clock is a one-cycle enable every eighth bit.
   typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_SHIFT = 2'b01, ST_HOLD = 2'b11} mls_state_e;
   typedef struct packed {
      logic [2:0] psync;
      logic [2:0] nsync;
      logic [2:0] bit_cnt;
      logic [1:0] div_cnt;
      logic [7:0] rx_shift;
      logic [7:0] tx_shift;
      logic [4:0] delay;
      mls_state_e state;
      logic word_en;
      logic pad_p_out;
      logic pad_n_out;
      logic pad_p_oe;
      logic pad_n_oe;
      logic core_clk;
      logic lp_p;
      logic lp_n;
      logic [7:0] push_word;
      logic push;
   } mls_lane_s;
   mls_lane_s cur;
   mls_lane_s next_cur;
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic [WIDTH-1:0] fifo_out_data;
   logic rx_pad;
   mls_fifo #(.WIDTH(WIDTH), .DEPTH(DEPTH)) u_fifo
   (
      .clk(CLK),
      .reset_n(RESET_N),
      .clear(LINK.rx_reset),
      .in_data(cur.push_word),
      .in_valid(cur.push && FIFO_ON),
      .in_ready(fifo_in_ready),
      .out_data(fifo_out_data),
      .out_valid(fifo_out_valid),
      .out_ready(LINK.fifo_read)
   );
   // Receive bit is only sensed while the core has the buffer on and termination in.
   assign rx_pad = LINK.hs_rx_buffer_on && LINK.hs_rx_termination_on && cur.psync[2] && !cur.nsync[2];
   always_comb
   begin
      next_cur = cur;
      next_cur.psync = {cur.psync[1:0], PAD_P_IN};
      next_cur.nsync = {cur.nsync[1:0], PAD_N_IN};
      next_cur.push = 1'b0;
      next_cur.word_en = (cur.bit_cnt == mls_pkg::BIT_LAST);
      next_cur.bit_cnt = cur.bit_cnt + 3'h1;
      next_cur.div_cnt = cur.div_cnt + 2'h1;
      if (cur.div_cnt == mls_pkg::DIV_LAST)
      begin
         next_cur.core_clk = !cur.core_clk;
      end
      if (cur.psync[2] == cur.psync[1])
      begin
         next_cur.lp_p = cur.psync[2];
      end
      if (cur.nsync[2] == cur.nsync[1])
      begin
         next_cur.lp_n = cur.nsync[2];
      end
      next_cur.rx_shift = {cur.rx_shift[6:0], rx_pad};
      if (cur.bit_cnt == mls_pkg::BIT_LAST)
      begin
         next_cur.push_word = {cur.rx_shift[6:0], rx_pad};
         next_cur.push = LINK.hs_rx_buffer_on;
      end
      unique case (cur.state)
         ST_IDLE:
         begin
            if (LINK.hs_tx_drive_en && cur.bit_cnt == mls_pkg::BIT_LAST)
            begin
               next_cur.tx_shift = LINK.hs_tx_word;
               next_cur.state = ST_SHIFT;
            end
         end
         ST_SHIFT:
         begin
            next_cur.tx_shift = {cur.tx_shift[6:0], 1'b0};
            if (cur.bit_cnt == mls_pkg::BIT_LAST)
            begin
               next_cur.tx_shift = LINK.hs_tx_word;
               next_cur.state = LINK.hs_tx_drive_en ? ST_SHIFT : ST_HOLD;
            end
         end
         ST_HOLD:
         begin
            next_cur.state = ST_IDLE;
         end
         default:
         begin
            next_cur.state = ST_IDLE;
         end
      endcase
      if (cur.state == ST_SHIFT)
      begin
         next_cur.pad_p_out = cur.tx_shift[7];
         next_cur.pad_n_out = !cur.tx_shift[7];
         next_cur.pad_p_oe = 1'b1;
         next_cur.pad_n_oe = 1'b1;
      end
      else
      begin
         next_cur.pad_p_out = LINK.lowpower_pos_pad_drive;
         next_cur.pad_n_out = LINK.lowpower_neg_pad_drive;
         next_cur.pad_p_oe = LINK.lowpower_pos_drive_en;
         next_cur.pad_n_oe = LINK.lowpower_neg_drive_en;
      end
      if (cur.word_en)
      begin
         if (LINK.delay_counter_clear)
         begin
            next_cur.delay = mls_pkg::DELAY_INIT;
         end
         else if (LINK.delay_adjust_strobe && LINK.delay_step_up && cur.delay != mls_pkg::DELAY_MAX)
         begin
            next_cur.delay = cur.delay + 5'h01;
         end
         else if (LINK.delay_adjust_strobe && !LINK.delay_step_up && cur.delay != mls_pkg::DELAY_INIT)
         begin
            next_cur.delay = cur.delay - 5'h01;
         end
      end
      if (LINK.rx_reset)
      begin
         next_cur.rx_shift = mls_pkg::WORD_ZERO;
         next_cur.push = 1'b0;
      end
      if (LINK.tx_reset)
      begin
         next_cur.tx_shift = mls_pkg::WORD_ZERO;
         next_cur.state = ST_IDLE;
      end
   end
   always_ff @(posedge CLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         cur <= '0;
      end
      else
      begin
         cur <= next_cur;
      end
   end
   assign LINK.hs_rx_word = FIFO_ON ? fifo_out_data : cur.push_word;
   assign LINK.hs_rx_valid = FIFO_ON ? fifo_out_valid : cur.push;
   assign LINK.fifo_empty = !fifo_out_valid;
   assign LINK.lowpower_pos_pad_level = cur.lp_p;
   assign LINK.lowpower_neg_pad_level = cur.lp_n;
   assign LINK.delay_setting = cur.delay;
   assign LINK.word_tick = cur.word_en;
   assign PAD_P_OUT = cur.pad_p_out;
   assign PAD_N_OUT = cur.pad_n_out;
   assign PAD_P_OE = cur.pad_p_oe;
   assign PAD_N_OE = cur.pad_n_oe;
   // Forwarded clocks are for neighbouring receive data lanes only.
   assign CLOCK_LANE_WORD_CLOCK_FWD = cur.word_en;
   assign CLOCK_LANE_BIT_CLOCK_FWD = cur.bit_cnt[0];
   assign CLOCK_LANE_CORE_CLOCK = cur.core_clk;
endmodule : mls_lane
`default_nettype wire

// File: rtl/mls_pkg.sv
// Constants and types used by the lane end and assertions of the MIPI lane model.
package mls_pkg;
   localparam int WORD_W = 8;
   localparam int FIFO_DEPTH = 8;
   localparam int DELAY_W = 5;
   localparam logic [4:0] DELAY_INIT = 5'h00;
   localparam logic [4:0] DELAY_MAX = 5'h1F;
   localparam logic [2:0] BIT_LAST = 3'h7;
   localparam logic [2:0] BIT_FIRST = 3'h0;
   localparam logic [1:0] DIV_LAST = 2'h3;
   localparam logic [1:0] SYNC_ZERO = 2'h0;
   localparam logic [7:0] WORD_ZERO = 8'h00;
   localparam real CLK_NS = 50.0;
   typedef logic [WORD_W-1:0] mls_word_t;
endpackage : mls_pkg

// File: rtl/mls_fifo.sv
// Parameterised valid/ready FIFO used on the receive word path.
`timescale 1ns/1ps
`default_nettype none
module mls_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
)
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic clear,
   input wire logic [WIDTH-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   output logic [WIDTH-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wp;
   logic [AW-1:0] rp;
   logic [AW:0] cnt;
   logic push;
   logic pop;
   assign in_ready = (cnt != DEPTH[AW:0]);
   assign out_valid = (cnt != '0);
   assign out_data = mem[rp];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   always_ff @(posedge clk)
   begin
      if (push)
      begin
         mem[wp] <= in_data;
      end
   end
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         wp <= '0;
         rp <= '0;
         cnt <= '0;
      end
      else if (clear)
      begin
         wp <= '0;
         rp <= '0;
         cnt <= '0;
      end
      else
      begin
         if (push)
         begin
            wp <= (wp == AW'(DEPTH - 1)) ? '0 : wp + 1'b1;
         end
         if (pop)
         begin
            rp <= (rp == AW'(DEPTH - 1)) ? '0 : rp + 1'b1;
         end
         cnt <= cnt + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule : mls_fifo
`default_nettype wire

// File: rtl/mls_if.sv
// Lane link between the core-side controller end and the lane end.
`timescale 1ns/1ps
`default_nettype none
interface mls_if;
   logic [7:0] hs_rx_word;
   logic hs_rx_valid;
   logic fifo_empty;
   logic fifo_read;
   logic rx_reset;
   logic lowpower_pos_pad_level;
   logic lowpower_neg_pad_level;
   logic lowpower_pos_pad_drive;
   logic lowpower_neg_pad_drive;
   logic lowpower_pos_drive_en;
   logic lowpower_neg_drive_en;
   logic hs_rx_buffer_on;
   logic hs_rx_termination_on;
   logic delay_adjust_strobe;
   logic delay_step_up;
   logic delay_counter_clear;
   logic [4:0] delay_setting;
   logic [7:0] hs_tx_word;
   logic hs_tx_drive_en;
   logic tx_reset;
   logic word_tick;
   modport lane
   (
      output hs_rx_word, hs_rx_valid, fifo_empty, lowpower_pos_pad_level, lowpower_neg_pad_level,
      output delay_setting, word_tick,
      input fifo_read, rx_reset, lowpower_pos_pad_drive, lowpower_neg_pad_drive,
      input lowpower_pos_drive_en, lowpower_neg_drive_en, hs_rx_buffer_on, hs_rx_termination_on,
      input delay_adjust_strobe, delay_step_up, delay_counter_clear, hs_tx_word, hs_tx_drive_en,
      input tx_reset
   );
   modport core
   (
      input hs_rx_word, hs_rx_valid, fifo_empty, lowpower_pos_pad_level, lowpower_neg_pad_level,
      input delay_setting, word_tick,
      output fifo_read, rx_reset, lowpower_pos_pad_drive, lowpower_neg_pad_drive,
      output lowpower_pos_drive_en, lowpower_neg_drive_en, hs_rx_buffer_on, hs_rx_termination_on,
      output delay_adjust_strobe, delay_step_up, delay_counter_clear, hs_tx_word, hs_tx_drive_en,
      output tx_reset
   );
endinterface : mls_if
`default_nettype wire

// File: rtl/mls_core.sv
// Core end: the controller side that drives the lane's control inputs and takes its words.
`timescale 1ns/1ps
`default_nettype none
module mls_core
(
   input wire logic CLK,
   input wire logic RESET_N,
   mls_if.core LINK,
   input wire logic RX_ENABLE,
   input wire logic RX_RESET,
   input wire logic TX_RESET,
   input wire logic [7:0] TX_WORD,
   input wire logic TX_SEND,
   input wire logic LP_P_DRIVE,
   input wire logic LP_N_DRIVE,
   input wire logic LP_P_EN,
   input wire logic LP_N_EN,
   input wire logic DELAY_STEP,
   input wire logic DELAY_UP,
   input wire logic DELAY_CLEAR,
   output logic [7:0] RX_WORD,
   output logic RX_WORD_VALID,
   output logic LP_P_LEVEL,
   output logic LP_N_LEVEL
);
   typedef struct packed {
      logic [7:0] rx_word;
      logic rx_valid;
      logic lp_p;
      logic lp_n;
      logic step_pend;
   } mls_core_s;
   mls_core_s cur;
   mls_core_s next_cur;
   logic pop;
   // Pop whenever a word is waiting.
   assign pop = !LINK.fifo_empty;
   always_comb
   begin
      next_cur = cur;
      next_cur.rx_valid = pop;
      if (pop)
      begin
         next_cur.rx_word = LINK.hs_rx_word;
      end
      next_cur.lp_p = LINK.lowpower_pos_pad_level;
      next_cur.lp_n = LINK.lowpower_neg_pad_level;
      // A step request waits for the next word tick so it acts once.
      if (DELAY_STEP)
      begin
         next_cur.step_pend = 1'b1;
      end
      else if (LINK.word_tick)
      begin
         next_cur.step_pend = 1'b0;
      end
   end
   always_ff @(posedge CLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         cur <= '0;
      end
      else
      begin
         cur <= next_cur;
      end
   end
   assign LINK.fifo_read = pop;
   assign LINK.rx_reset = RX_RESET;
   assign LINK.tx_reset = TX_RESET;
   assign LINK.hs_rx_buffer_on = RX_ENABLE;
   assign LINK.hs_rx_termination_on = RX_ENABLE;
   assign LINK.hs_tx_word = TX_WORD;
   assign LINK.hs_tx_drive_en = TX_SEND;
   assign LINK.lowpower_pos_pad_drive = LP_P_DRIVE;
   assign LINK.lowpower_neg_pad_drive = LP_N_DRIVE;
   assign LINK.lowpower_pos_drive_en = LP_P_EN;
   assign LINK.lowpower_neg_drive_en = LP_N_EN;
   assign LINK.delay_adjust_strobe = cur.step_pend;
   assign LINK.delay_step_up = DELAY_UP;
   assign LINK.delay_counter_clear = DELAY_CLEAR;
   assign RX_WORD = cur.rx_word;
   assign RX_WORD_VALID = cur.rx_valid;
   assign LP_P_LEVEL = cur.lp_p;
   assign LP_N_LEVEL = cur.lp_n;
endmodule : mls_core
`default_nettype wire

// File: dv/mls_link_asserts.sv
// Assertions on the lane link signals.
`timescale 1ns/1ps
`default_nettype none
module mls_link_asserts
(
   input wire logic CLK,
   input wire logic RESET_N,
   input wire logic fifo_empty,
   input wire logic fifo_read,
   input wire logic rx_reset,
   input wire logic hs_rx_buffer_on,
   input wire logic hs_rx_termination_on,
   input wire logic delay_step_up,
   input wire logic delay_counter_clear,
   input wire logic [4:0] delay_setting,
   input wire logic word_tick
);
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!RESET_N);
   sequence gap_s;
      !word_tick [*7] ##1 word_tick;
   endsequence
   word_period_a: assert property (word_tick |=> gap_s)
      else $error("word tick period wrong");
   clear_empty_a: assert property (rx_reset |=> fifo_empty)
      else $error("fifo not empty after clear");
   pop_guard_a: assert property (fifo_read && !rx_reset |=> fifo_empty)
      else $error("fifo not drained by pop");
   rx_term_a: assert property (hs_rx_buffer_on == hs_rx_termination_on)
      else $error("termination differs from buffer");
   dly_clear_a: assert property (delay_counter_clear && word_tick |=> delay_setting == mls_pkg::DELAY_INIT)
      else $error("delay not cleared");
   dly_when_a: assert property ($changed(delay_setting) |-> word_tick || $past(word_tick)
      || $past(delay_counter_clear) || $past(rx_reset))
      else $error("delay moved off word tick");
   dly_dir_a: assert property (delay_setting > $past(delay_setting) |-> $past(delay_step_up))
      else $error("delay rose while stepping down");
   dly_top_a: assert property ($past(delay_setting) == mls_pkg::DELAY_MAX && $past(delay_step_up)
      && !$past(delay_counter_clear) && !$past(rx_reset) |-> delay_setting == mls_pkg::DELAY_MAX)
      else $error("delay wrapped at top");
endmodule : mls_link_asserts
`default_nettype wire

// File: dv/mls_lane_serdes_test.sv
// Bench joining the core end and the lane end across the lane link.
`timescale 1ns/1ps
`default_nettype none
module mls_lane_serdes_test;
   logic CLK = 1'b0;
   logic RESET_N = 1'b0;
   logic rx_en = 1'b0, rx_rst = 1'b0, tx_rst = 1'b0, tx_send = 1'b0;
   logic lp_pd = 1'b0, lp_nd = 1'b0, lp_pe = 1'b0, lp_ne = 1'b0;
   logic d_step = 1'b0, d_up = 1'b0, d_clr = 1'b0, pad_p = 1'b0, pad_n = 1'b1;
   logic [7:0] tx_word = 8'h00;
   logic [7:0] rx_word, b, c, w;
   logic [15:0] got;
   logic rx_valid, lp_pl, lp_nl, p_out, n_out, p_oe, n_oe, wclk, bclk, cclk, p_in, n_in, pb, pc, nok;
   int mismatches = 0, checks_done = 0, cycles = 0, n;
   always #25 CLK = ~CLK;
   // Pads are driven by the lane when enabled, otherwise by the bench.
   assign p_in = p_oe ? p_out : pad_p;
   assign n_in = n_oe ? n_out : pad_n;
   mls_if mls_if_inst ();
   mls_lane mls_lane_inst (.CLK(CLK), .RESET_N(RESET_N), .LINK(mls_if_inst.lane), .PAD_P_IN(p_in),
      .PAD_N_IN(n_in), .PAD_P_OUT(p_out), .PAD_N_OUT(n_out), .PAD_P_OE(p_oe), .PAD_N_OE(n_oe),
      .CLOCK_LANE_WORD_CLOCK_FWD(wclk), .CLOCK_LANE_BIT_CLOCK_FWD(bclk), .CLOCK_LANE_CORE_CLOCK(cclk));
   mls_core mls_core_inst (.CLK(CLK), .RESET_N(RESET_N), .LINK(mls_if_inst.core), .RX_ENABLE(rx_en),
      .RX_RESET(rx_rst), .TX_RESET(tx_rst), .TX_WORD(tx_word), .TX_SEND(tx_send), .LP_P_DRIVE(lp_pd),
      .LP_N_DRIVE(lp_nd), .LP_P_EN(lp_pe), .LP_N_EN(lp_ne), .DELAY_STEP(d_step), .DELAY_UP(d_up),
      .DELAY_CLEAR(d_clr), .RX_WORD(rx_word), .RX_WORD_VALID(rx_valid), .LP_P_LEVEL(lp_pl),
      .LP_N_LEVEL(lp_nl));
   mls_link_asserts mls_link_asserts_inst (.CLK(CLK), .RESET_N(RESET_N),
      .fifo_empty(mls_if_inst.fifo_empty), .fifo_read(mls_if_inst.fifo_read),
      .rx_reset(mls_if_inst.rx_reset), .hs_rx_buffer_on(mls_if_inst.hs_rx_buffer_on),
      .hs_rx_termination_on(mls_if_inst.hs_rx_termination_on), .delay_step_up(mls_if_inst.delay_step_up),
      .delay_counter_clear(mls_if_inst.delay_counter_clear), .delay_setting(mls_if_inst.delay_setting),
      .word_tick(mls_if_inst.word_tick));
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      checks_done++;
      if (g !== e)
         $display("wrong value at %0t ns: got %h expected %h", $time, g, e);
      if (g !== e)
         mismatches++;
   endtask : chk
   task automatic tick(input int k);
      repeat (k) @(posedge CLK);
      #1;
   endtask : tick
   task automatic pulses(input int lim, input int want);
      n = 0;
      for (int i = 0; i < lim && n < want; i++)
      begin
         tick(1);
         n += int'(rx_valid === 1'b1);
      end
   endtask : pulses
   task automatic dstep(input logic up, input int k);
      repeat (k)
      begin
         @(posedge CLK);
         d_up <= up;
         d_step <= 1'b1;
         @(posedge CLK);
         d_step <= 1'b0;
         tick(12);
      end
   endtask : dstep
   task automatic dclear();
      @(posedge CLK);
      d_clr <= 1'b1;
      // The clear is taken on a word tick, so it is held across a whole word.
      repeat (9) @(posedge CLK);
      d_clr <= 1'b0;
      tick(2);
   endtask : dclear
   task automatic rx_take(input logic lvl, input logic [7:0] e);
      @(posedge CLK);
      pad_p <= lvl;
      pad_n <= ~lvl;
      pulses(200, 3);
      chk(rx_word, e);
   endtask : rx_take
   task automatic final_report();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : final_report
   always @(posedge CLK)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         mismatches++;
         final_report();
      end
   end
   initial
   begin
      repeat (4) @(posedge CLK);
      RESET_N <= 1'b1;
      tick(2);
      chk(mls_if_inst.fifo_empty, 1'b1);
      chk(rx_valid, 1'b0);
      {b, c, w} = '0;
      for (int i = 0; i < 64; i++)
      begin
         pb = bclk;
         pc = cclk;
         tick(1);
         b += 8'(bclk && !pb);
         c += 8'(cclk && !pc);
         w += 8'(wclk);
      end
      chk(b, 8'h20);
      chk(c, 8'h08);
      chk(w, 8'h08);
      $display("clock test done");
      @(posedge CLK);
      lp_pe <= 1'b1;
      lp_ne <= 1'b1;
      lp_pd <= 1'b1;
      tick(10);
      chk({p_oe, n_oe, p_out, n_out}, 8'h0E);
      chk({lp_pl, lp_nl}, 8'h02);
      @(posedge CLK);
      lp_pe <= 1'b0;
      lp_ne <= 1'b0;
      tick(10);
      chk({p_oe, n_oe, lp_pl, lp_nl}, 8'h01);
      $display("low power test done");
      dclear();
      dstep(1'b1, 3);
      chk(mls_if_inst.delay_setting, 8'h03);
      dstep(1'b0, 1);
      chk(mls_if_inst.delay_setting, 8'h02);
      dclear();
      chk(mls_if_inst.delay_setting, 8'h00);
      dstep(1'b0, 1);
      chk(mls_if_inst.delay_setting, 8'h00);
      dstep(1'b1, 33);
      chk(mls_if_inst.delay_setting, 8'h1F);
      $display("delay test done");
      @(posedge CLK);
      tx_word <= 8'hC3;
      tx_send <= 1'b1;
      for (int i = 0; i < 40 && p_oe !== 1'b1; i++)
         tick(1);
      nok = 1'b1;
      for (int i = 0; i < 16; i++)
      begin
         got = {got[14:0], p_out};
         nok &= (n_out === ~p_out);
         @(posedge CLK);
         if (i == 0)
            tx_word <= 8'h3C;
         if (i == 7)
            tx_send <= 1'b0;
         #1;
      end
      chk(got[15:8], 8'hC3);
      chk(got[7:0], 8'h3C);
      chk(nok, 1'b1);
      tick(3);
      chk(p_oe, 1'b0);
      @(posedge CLK);
      tx_send <= 1'b1;
      tick(12);
      @(posedge CLK);
      tx_rst <= 1'b1;
      tx_send <= 1'b0;
      tick(3);
      chk(p_oe, 1'b0);
      @(posedge CLK);
      tx_rst <= 1'b0;
      $display("transmit test done");
      rx_en <= 1'b1;
      rx_take(1'b1, 8'hFF);
      rx_take(1'b0, 8'h00);
      @(posedge CLK);
      rx_en <= 1'b0;
      pad_p <= 1'b1;
      pad_n <= 1'b0;
      tick(20);
      pulses(40, 1);
      chk(8'(n), 8'h00);
      @(posedge CLK);
      rx_en <= 1'b1;
      rx_rst <= 1'b1;
      tick(2);
      chk(mls_if_inst.fifo_empty, 1'b1);
      @(posedge CLK);
      rx_rst <= 1'b0;
      pulses(60, 1);
      chk(8'(n), 8'h01);
      $display("receive test done");
      final_report();
   end
endmodule : mls_lane_serdes_test
`default_nettype wire
